// [core/pcm_seq_pkg.sv]
// Package of command codes, register map and timing for the memory command sequencer
package pcm_seq_pkg;

	// Device command codes
	localparam logic [7:0] CMD_READ_ARRAY   = 8'h00_FF;
	localparam logic [7:0] CMD_READ_STATUS  = 8'h00_70;
	localparam logic [7:0] CMD_SUSPEND      = 8'h00_B0;
	localparam logic [7:0] CMD_CONFIRM      = 8'h00_D0;
	localparam logic [7:0] CMD_PROGRAM      = 8'h00_40;
	localparam logic [7:0] CMD_LOCK_SETUP   = 8'h00_60;
	localparam logic [7:0] CMD_LOCK         = 8'h00_01;
	localparam logic [7:0] CMD_LOCKDOWN     = 8'h00_2F;
	localparam logic [7:0] CMD_READ_ID      = 8'h00_90;
	localparam logic [7:0] CMD_PROT_SETUP   = 8'h00_C0;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h00_50;

	// Status bit positions
	localparam int MACHINE_READY_BIT = 7;
	localparam int PROGRAM_FAIL_BIT  = 4;
	localparam int SUPPLY_FAIL_BIT   = 3;
	localparam int LOCK_ABORT_BIT    = 1;
	localparam int LOCK_LINE_BIT     = 0;
	localparam int LOCKDOWN_LINE_BIT = 1;
	localparam logic [22:0] LOCK_STATUS_OFFSET = 23'h00_0002;

	// Register byte addresses
	localparam logic [7:0] REG_CTRL   = 8'h00_00;
	localparam logic [7:0] REG_ADDR   = 8'h00_04;
	localparam logic [7:0] REG_DATA   = 8'h00_08;
	localparam logic [7:0] REG_RESULT = 8'h00_0C;
	localparam logic [7:0] REG_IRQ_ST = 8'h00_10;
	localparam logic [7:0] REG_IRQ_MK = 8'h00_14;

	// Interrupt bit positions
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_ERROR = 1;
	localparam int IRQ_W     = 2;

	// Control register fields
	localparam int CTRL_START = 0;
	localparam int CTRL_OP_LO = 4;
	localparam int CTRL_OP_HI = 7;

	// Strobe timing on the pins
	localparam int STROBE_NS     = 70;
	localparam int CLK_NS        = 10;
	localparam int STROBE_CYCLES = (STROBE_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [3:0] {
		OP_ERASE_SUSPEND = 4'h0_1,
		OP_ERASE_RESUME  = 4'h0_2,
		OP_LOCK          = 4'h0_3,
		OP_UNLOCK        = 4'h0_4,
		OP_LOCKDOWN      = 4'h0_5,
		OP_LOCK_STATUS   = 4'h0_6,
		OP_PROT_PROGRAM  = 4'h0_7,
		OP_CLEAR_STATUS  = 4'h0_8,
		OP_READ_ARRAY    = 4'h0_9,
		OP_PROGRAM       = 4'h0_A,
		OP_READ_WORD     = 4'h0_B
	} op_e;

	// One bus cycle toward the memory pins
	typedef struct packed {
		logic        write;
		logic [22:0] addr;
		logic [15:0] data;
	} bus_req_s;

endpackage

// [core/pcm_bus_cycle.sv]
// One asynchronous read or write cycle on the memory pins
`timescale 1ns/10ps
module pcm_bus_cycle import pcm_seq_pkg::*; #(
	parameter int HOLD = STROBE_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        start,
	input  wire bus_req_s    req,
	output logic             done,
	output logic [15:0]      rdata,
	output logic             chip_en_n,
	output logic             out_en_n,
	output logic             write_en_n,
	output logic [22:0]      addr,
	output logic [15:0]      dq_out,
	output logic             dq_oe,
	input  wire logic [15:0] dq_in
);

	typedef enum logic [1:0] {IDLE = 2'b00, STROBE = 2'b01, GAP = 2'b11} cyc_e;

	cyc_e        state_reg;
	logic [7:0]  count_reg;
	logic        write_reg;
	logic        last;

	assign last = (count_reg == 8'(HOLD - 1));

	// Each cycle drops and restores the strobes, so status is refreshed every read
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_reg  <= IDLE;
			count_reg  <= '0;
			write_reg  <= 1'b0;
			chip_en_n  <= 1'b1;
			out_en_n   <= 1'b1;
			write_en_n <= 1'b1;
			addr       <= '0;
			dq_out     <= '0;
			dq_oe      <= 1'b0;
			rdata      <= '0;
			done       <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state_reg)
				IDLE: begin
					count_reg <= '0;
					if (start) begin
						state_reg  <= STROBE;
						write_reg  <= req.write;
						addr       <= req.addr;
						dq_out     <= req.data;
						dq_oe      <= req.write;
						chip_en_n  <= 1'b0;
						out_en_n   <= req.write;
						write_en_n <= !req.write;
					end
				end
				STROBE: begin
					count_reg <= count_reg + 8'd1;
					if (last) begin
						if (!write_reg) begin
							rdata <= dq_in;
						end
						chip_en_n  <= 1'b1;
						out_en_n   <= 1'b1;
						write_en_n <= 1'b1;
						state_reg  <= GAP;
					end
				end
				GAP: begin
					dq_oe     <= 1'b0;
					done      <= 1'b1;
					state_reg <= IDLE;
				end
				default: state_reg <= IDLE;
			endcase
		end
	end

	logic [7:0]  low_cnt_reg;

	// Counts low cycles of chip enable, so the width check needs no long repetition
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			low_cnt_reg <= '0;
		end else if (chip_en_n) begin
			low_cnt_reg <= '0;
		end else begin
			low_cnt_reg <= low_cnt_reg + 8'd1;
		end
	end

	strobe_width_a : assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(chip_en_n) |-> low_cnt_reg >= 8'(HOLD)) else $error("strobe too short");

endmodule // pcm_bus_cycle

// [core/pcm_command_sequencer.sv]
// Host-side sequencer that issues memory command procedures from APB orders
//
// Contract
// - Suspend: read-status then suspend code
// - Toggle strobes to refresh status
// - Suspended erase allows other reads, programs; resume
// - Lock change: setup then lock/unlock/lockdown
// - Protection program: setup, data, poll
// - Read-array command ends each sequence; program, read word, erase suspend, erase resume and any sequence whose poll sees an error end without it
// - Clear status before retry
// - Error check may follow many programs
`timescale 1ns/10ps
module pcm_command_sequencer import pcm_seq_pkg::*; #(
	parameter int HOLD = STROBE_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic             chip_en_n,
	output logic             out_en_n,
	output logic             write_en_n,
	output logic [22:0]      mem_addr,
	output logic [15:0]      dq_out,
	output logic             dq_oe,
	input  wire logic [15:0] dq_in
);

	////////////////////////////////////////////////////////////////////////
	// Sequencer states

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_ISSUE = 3'b001,
		S_WAIT  = 3'b011,
		S_NEXT  = 3'b010,
		S_DONE  = 3'b110
	} seq_e;

	seq_e          state_reg;
	seq_e          state_next;
	op_e           op_reg;
	logic [22:0]   target_reg;
	logic [15:0]   data_reg;
	logic [2:0]    step_reg;
	logic [15:0]   result_reg;
	logic          error_reg;
	logic [IRQ_W-1:0] irq_status_reg;
	logic [IRQ_W-1:0] irq_mask_reg;
	logic          cyc_start;
	logic          cyc_done;
	logic [15:0]   cyc_rdata;
	bus_req_s      cur_req;
	logic          is_poll;
	logic          is_last;
	logic          seq_done;
	logic          ready_seen;
	logic          err_seen;

	// Write cycle helper
	function automatic bus_req_s wr(input logic [22:0] a, input logic [15:0] d);
		bus_req_s r;
		r.write = 1'b1;
		r.addr  = a;
		r.data  = d;
		return r;
	endfunction

	// Read cycle helper
	function automatic bus_req_s rd(input logic [22:0] a);
		bus_req_s r;
		r.write = 1'b0;
		r.addr  = a;
		r.data  = '0;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait state, unmapped reads return zero with error

	logic apb_wr;
	logic apb_rd;
	logic mapped;
	logic busy;
	logic start_wr;

	assign apb_wr   = psel && penable && pwrite;
	assign apb_rd   = psel && penable && !pwrite;
	assign pready   = 1'b1;
	assign busy     = (state_reg != S_IDLE);
	assign mapped   = (paddr == REG_CTRL) || (paddr == REG_ADDR) || (paddr == REG_DATA)
		|| (paddr == REG_RESULT) || (paddr == REG_IRQ_ST) || (paddr == REG_IRQ_MK);
	assign pslverr  = psel && penable && !mapped;
	assign start_wr = apb_wr && (paddr == REG_CTRL) && pwdata[CTRL_START] && !busy;

	always_comb begin
		prdata = '0;
		if (apb_rd) begin
			case (paddr)
				REG_CTRL:   prdata = {24'h00_0000, op_reg, 3'b000, busy};
				REG_ADDR:   prdata = {9'h000, target_reg};
				REG_DATA:   prdata = {16'h0000, data_reg};
				REG_RESULT: prdata = {15'h0000, error_reg, result_reg};
				REG_IRQ_ST: prdata = {30'h0000_0000, irq_status_reg};
				REG_IRQ_MK: prdata = {30'h0000_0000, irq_mask_reg};
				default:    prdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Step table per procedure

	logic [2:0] poll_step;
	logic [2:0] last_step;

	// Polling step number and final step, per operation
	always_comb begin
		poll_step = 3'd7;
		last_step = 3'd0;
		case (op_reg)
			OP_ERASE_SUSPEND: begin poll_step = 3'd2; last_step = 3'd2; end
			OP_ERASE_RESUME:  begin last_step = 3'd0; end
			OP_LOCK, OP_UNLOCK, OP_LOCKDOWN: begin poll_step = 3'd2; last_step = 3'd3; end
			OP_LOCK_STATUS:   begin last_step = 3'd2; end
			OP_PROT_PROGRAM:  begin poll_step = 3'd2; last_step = 3'd3; end
			OP_PROGRAM:       begin poll_step = 3'd2; last_step = 3'd2; end
			OP_CLEAR_STATUS:  begin last_step = 3'd1; end
			OP_READ_ARRAY:    begin last_step = 3'd0; end
			OP_READ_WORD:     begin last_step = 3'd1; end
			default:          begin last_step = 3'd0; end
		endcase
	end

	// Bus cycle for the current step
	always_comb begin
		cur_req = wr(target_reg, {8'h00, CMD_READ_ARRAY});
		case (op_reg)
			OP_ERASE_SUSPEND: case (step_reg)
				3'd0:    cur_req = wr(target_reg, {8'h00, CMD_READ_STATUS});
				3'd1:    cur_req = wr(target_reg, {8'h00, CMD_SUSPEND});
				default: cur_req = rd(target_reg);
			endcase
			OP_ERASE_RESUME: cur_req = wr(target_reg, {8'h00, CMD_CONFIRM});
			OP_LOCK, OP_UNLOCK, OP_LOCKDOWN: case (step_reg)
				3'd0:    cur_req = wr(target_reg, {8'h00, CMD_LOCK_SETUP});
				3'd1:    cur_req = wr(target_reg, {8'h00, (op_reg == OP_LOCK) ? CMD_LOCK :
					(op_reg == OP_UNLOCK) ? CMD_CONFIRM : CMD_LOCKDOWN});
				3'd2:    cur_req = rd(target_reg);
				default: cur_req = wr(target_reg, {8'h00, CMD_READ_ARRAY});
			endcase
			OP_LOCK_STATUS: case (step_reg)
				3'd0:    cur_req = wr(target_reg + LOCK_STATUS_OFFSET, {8'h00, CMD_READ_ID});
				3'd1:    cur_req = rd(target_reg + LOCK_STATUS_OFFSET);
				default: cur_req = wr(target_reg, {8'h00, CMD_READ_ARRAY});
			endcase
			OP_PROT_PROGRAM, OP_PROGRAM: case (step_reg)
				3'd0:    cur_req = wr(target_reg, {8'h00, (op_reg == OP_PROGRAM) ?
					CMD_PROGRAM : CMD_PROT_SETUP});
				3'd1:    cur_req = wr(target_reg, data_reg);
				3'd2:    cur_req = rd(target_reg);
				default: cur_req = wr(target_reg, {8'h00, CMD_READ_ARRAY});
			endcase
			OP_CLEAR_STATUS: case (step_reg)
				3'd0:    cur_req = wr(target_reg, {8'h00, CMD_CLEAR_STATUS});
				default: cur_req = wr(target_reg, {8'h00, CMD_READ_ARRAY});
			endcase
			OP_READ_ARRAY: cur_req = wr(target_reg, {8'h00, CMD_READ_ARRAY});
			OP_READ_WORD: case (step_reg)
				3'd0:    cur_req = wr(target_reg, {8'h00, CMD_READ_ARRAY});
				default: cur_req = rd(target_reg);
			endcase
			default: cur_req = wr(target_reg, {8'h00, CMD_READ_ARRAY});
		endcase
	end

	assign is_poll    = (step_reg == poll_step);
	assign is_last    = (step_reg == last_step);
	assign ready_seen = cyc_rdata[MACHINE_READY_BIT];
	assign err_seen   = cyc_rdata[PROGRAM_FAIL_BIT] || cyc_rdata[SUPPLY_FAIL_BIT]
		|| cyc_rdata[LOCK_ABORT_BIT];
	assign seq_done   = (state_reg == S_DONE);
	assign cyc_start  = (state_reg == S_ISSUE);

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE:  if (start_wr) state_next = S_ISSUE;
			S_ISSUE: state_next = S_WAIT;
			S_WAIT: begin
				if (cyc_done) begin
					// Busy status repeats the same read, each one a fresh strobe
					if (is_poll && !ready_seen) begin
						state_next = S_ISSUE;
					end else if (is_poll && err_seen) begin
						state_next = S_DONE;
					end else if (is_last) begin
						state_next = S_DONE;
					end else begin
						state_next = S_NEXT;
					end
				end
			end
			S_NEXT:  state_next = S_ISSUE;
			S_DONE:  state_next = S_IDLE;
			default: state_next = S_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_reg  <= S_IDLE;
			step_reg   <= '0;
			op_reg     <= OP_READ_ARRAY;
			target_reg <= '0;
			data_reg   <= '0;
			result_reg <= '0;
			error_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (start_wr) begin
				op_reg    <= op_e'(pwdata[CTRL_OP_HI:CTRL_OP_LO]);
				step_reg  <= '0;
				error_reg <= 1'b0;
			end
			if (state_reg == S_NEXT) begin
				step_reg <= step_reg + 3'd1;
			end
			if (apb_wr && !busy && paddr == REG_ADDR) begin
				target_reg <= pwdata[22:0];
			end
			if (apb_wr && !busy && paddr == REG_DATA) begin
				data_reg <= pwdata[15:0];
			end
			if (state_reg == S_WAIT && cyc_done && !cur_req.write) begin
				result_reg <= (op_reg == OP_LOCK_STATUS) ? {14'h0000,
					cyc_rdata[LOCKDOWN_LINE_BIT], cyc_rdata[LOCK_LINE_BIT]} : cyc_rdata;
				if (is_poll && ready_seen && err_seen) begin
					error_reg <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts: set wins over write-one-to-clear

	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;

	assign irq_set = {seq_done && error_reg, seq_done};
	assign irq_clr = (apb_wr && paddr == REG_IRQ_ST) ? pwdata[IRQ_W-1:0] : '0;
	assign irq     = |(irq_status_reg & irq_mask_reg);

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			irq_status_reg <= '0;
			irq_mask_reg   <= '0;
		end else begin
			irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
			if (apb_wr && paddr == REG_IRQ_MK) begin
				irq_mask_reg <= pwdata[IRQ_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin cycle engine

	pcm_bus_cycle #(.HOLD(HOLD)) cycle_u (
		.mclk       (mclk),
		.reset_n    (reset_n),
		.start      (cyc_start),
		.req        (cur_req),
		.done       (cyc_done),
		.rdata      (cyc_rdata),
		.chip_en_n  (chip_en_n),
		.out_en_n   (out_en_n),
		.write_en_n (write_en_n),
		.addr       (mem_addr),
		.dq_out     (dq_out),
		.dq_oe      (dq_oe),
		.dq_in      (dq_in)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks

	suspend_order_a : assert property (@(posedge mclk) disable iff (!reset_n)
		cyc_start && op_reg == OP_ERASE_SUSPEND && step_reg == 3'd1
		|-> cur_req.data[7:0] == CMD_SUSPEND) else $error("suspend code wrong");
	poll_retry_a : assert property (@(posedge mclk) disable iff (!reset_n)
		state_reg == S_WAIT && cyc_done && is_poll && !ready_seen
		|=> state_reg == S_ISSUE) else $error("busy poll not repeated");
	lock_confirm_a : assert property (@(posedge mclk) disable iff (!reset_n)
		cyc_start && op_reg == OP_UNLOCK && step_reg == 3'd1
		|-> cur_req.data[7:0] == CMD_CONFIRM) else $error("unlock code wrong");
	status_addr_a : assert property (@(posedge mclk) disable iff (!reset_n)
		cyc_start && op_reg == OP_LOCK_STATUS && step_reg == 3'd1
		|-> cur_req.addr == target_reg + LOCK_STATUS_OFFSET) else $error("bad addr");
	prot_setup_a : assert property (@(posedge mclk) disable iff (!reset_n)
		cyc_start && op_reg == OP_PROT_PROGRAM && step_reg == 3'd0
		|-> cur_req.data[7:0] == CMD_PROT_SETUP) else $error("setup code wrong");
	error_report_a : assert property (@(posedge mclk) disable iff (!reset_n)
		state_reg == S_WAIT && cyc_done && is_poll && ready_seen && err_seen
		|=> error_reg ##1 irq_status_reg[IRQ_ERROR]) else $error("error lost");
	final_array_a : assert property (@(posedge mclk) disable iff (!reset_n)
		cyc_start && op_reg == OP_LOCK && step_reg == 3'd3
		|-> cur_req.data[7:0] == CMD_READ_ARRAY) else $error("no read array");
	// A clear written in the finishing cycle must not swallow the done event
	done_sticky_a : assert property (@(posedge mclk) disable iff (!reset_n)
		seq_done |=> irq_status_reg[IRQ_DONE]) else $error("done flag lost");

endmodule // pcm_command_sequencer

// [tb/pcm_device_model.sv]
// Behavioural model of the memory device behind the pins
`timescale 1ns/10ps
module pcm_device_model import pcm_seq_pkg::*; #(
	parameter logic [22:0] PROT_LO = 23'h00_0080,
	parameter logic [22:0] PROT_HI = 23'h00_0108
) (
	input  wire logic        chip_en_n,
	input  wire logic        out_en_n,
	input  wire logic        write_en_n,
	input  wire logic [22:0] mem_addr,
	input  wire logic [15:0] dq_out,
	input  wire logic        dq_oe,
	input  wire logic        slow,
	input  wire logic        fail_prog,
	input  wire logic        supply_bad,
	output logic [15:0]      dq_in
);
	logic [15:0]  mem [logic [22:0]];
	logic [15:0]  prot [logic [22:0]];
	logic [127:0] lk, ldn;
	logic [1:0]   mode;
	logic [7:0]   pend, snap, hist0, hist1;
	logic         susp, f4, f3, f1;
	logic [22:0]  la;
	logic [15:0]  ld, rdv, held;
	logic [6:0]   b;
	int           busy;

	initial begin
		{lk, ldn, mode, pend, snap, hist0, hist1, susp, f4, f3, f1, held} = '0;
		busy = 0;
	end
	////////////////////////////////////////
	// Status only refreshes on a strobe fall, so a host that never toggles sees stale busy
	always @(negedge out_en_n, negedge chip_en_n) begin
		if (!out_en_n && !chip_en_n) begin
			snap = {busy == 0, 2'b00, f4, f3, 1'b0, f1, 1'b0};
			if (busy > 0) busy = busy - 1;
		end
	end
	always @* begin
		case (mode)
			2'd1: rdv = {8'h00, snap};
			2'd2: rdv = (mem_addr[15:0] == LOCK_STATUS_OFFSET[15:0]) ?
				{14'h0000, ldn[mem_addr[22:16]], lk[mem_addr[22:16]]} : 16'h0000;
			default: rdv = mem.exists(mem_addr) ? mem[mem_addr] : 16'hFFFF;
		endcase
		if (!chip_en_n && !out_en_n) held = rdv;
		if (!chip_en_n && !write_en_n) begin
			la = mem_addr;
			ld = dq_oe ? dq_out : ~dq_out;
		end
	end
	// Released bus shows the inverse of the last word, never a friendly value
	assign dq_in = (!chip_en_n && !out_en_n) ? rdv : ~held;
	////////////////////////////////////////
	always @(posedge write_en_n) begin
		hist1 = hist0;
		hist0 = ld[7:0];
		b = la[22:16];
		if (pend == CMD_LOCK_SETUP) begin
			if (ld[7:0] == CMD_LOCK) lk[b] = 1'b1;
			else if (ld[7:0] == CMD_LOCKDOWN) {ldn[b], lk[b]} = 2'b11;
			else if (ld[7:0] == CMD_CONFIRM && !ldn[b]) lk[b] = 1'b0;
			mode = 2'd1;
			busy = slow ? 2 : 0;
		end else if (pend == CMD_PROGRAM) begin
			if (supply_bad) f3 = 1'b1;
			if (f3) ;
			else if (lk[b]) f1 = 1'b1;
			else if (fail_prog) f4 = 1'b1;
			else mem[la] = ld;
			mode = 2'd1;
			busy = slow ? 2 : 0;
		end else if (pend == CMD_PROT_SETUP) begin
			if (la < PROT_LO || la > PROT_HI) f4 = 1'b1;
			else prot[la] = ld;
			mode = 2'd1;
			busy = slow ? 2 : 0;
		end else begin
			case (ld[7:0])
				CMD_READ_ARRAY: mode = 2'd0;
				CMD_READ_STATUS: mode = 2'd1;
				CMD_SUSPEND: begin
					susp = 1'b1;
					mode = 2'd1;
					busy = slow ? 2 : 0;
				end
				CMD_CONFIRM: susp = 1'b0;
				CMD_READ_ID: mode = 2'd2;
				CMD_CLEAR_STATUS: {f4, f3, f1} = 3'b000;
				default: ;
			endcase
		end
		if (pend == 8'h00 && (ld[7:0] == CMD_PROGRAM || ld[7:0] == CMD_LOCK_SETUP ||
			ld[7:0] == CMD_PROT_SETUP)) pend = ld[7:0];
		else pend = 8'h00;
	end
endmodule // pcm_device_model

// [tb/pcm_command_sequencer_bench.sv]
// Self-checking bench for the command sequencer against the device model
`timescale 1ns/10ps
module pcm_command_sequencer_bench import pcm_seq_pkg::*;;
	typedef struct packed {
		logic [31:0] v;
		logic [31:0] m;
	} note_s;
	localparam logic [31:0] M_ERR = 32'h0001_0000;
	logic        mclk, reset_n, psel, penable, pwrite, chk, perr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, irq, chip_en_n, out_en_n, write_en_n, dq_oe;
	logic        slow, fail_prog, supply_bad;
	logic [22:0] mem_addr;
	logic [15:0] dq_out, dq_in, wd;
	note_s       notes[$];
	note_s       nt;
	int          error_cnt, checks;
	op_e         lk_ops[4] = '{OP_LOCK, OP_UNLOCK, OP_LOCKDOWN, OP_UNLOCK};
	logic [1:0]  lk_exp[4] = '{2'b01, 2'b00, 2'b11, 2'b11};

	pcm_command_sequencer #(.HOLD(2)) dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .chip_en_n(chip_en_n),
		.out_en_n(out_en_n), .write_en_n(write_en_n), .mem_addr(mem_addr), .dq_out(dq_out),
		.dq_oe(dq_oe), .dq_in(dq_in));
	pcm_device_model part (.chip_en_n(chip_en_n), .out_en_n(out_en_n),
		.write_en_n(write_en_n), .mem_addr(mem_addr), .dq_out(dq_out), .dq_oe(dq_oe),
		.slow(slow), .fail_prog(fail_prog), .supply_bad(supply_bad), .dq_in(dq_in));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	////////////////////////////////////////
	// Oldest note is matched against each checked read as it completes
	always @(posedge mclk) begin
		if (psel && penable && pready && !pwrite && chk) begin
			checks++;
			if (notes.size() == 0) begin
				error_cnt++;
				$display("unexpected at %0t: read with no note", $time);
			end else begin
				nt = notes.pop_front();
				if ((prdata & nt.m) !== nt.v) begin
					error_cnt++;
					$display("unexpected at %0t: addr %h got %h want %h", $time, paddr, prdata, nt.v);
				end
			end
		end
	end

	task stop_test;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		chk <= c;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
			if (n > 50) begin
				error_cnt++;
				$display("unexpected at %0t: no pready", $time);
				stop_test();
			end
		end while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk <= 1'b0;
		@(posedge mclk);
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
		notes.push_back('{v, m});
		apb(1'b0, a, 32'h0000_0000, 1'b1);
	endtask

	// Zero irqs skips the interrupt check and leaves status bits standing
	task run(input op_e op, input logic [22:0] a, input logic [15:0] d, input logic [31:0] v,
		input logic [31:0] m, input logic [1:0] irqs);
		int n;
		n = 0;
		apb(1'b1, REG_ADDR, {9'h000, a}, 1'b0);
		apb(1'b1, REG_DATA, {16'h0000, d}, 1'b0);
		apb(1'b1, REG_CTRL, {24'h00_0000, op, 4'h1}, 1'b0);
		do begin
			apb(1'b0, REG_CTRL, 32'h0000_0000, 1'b0);
			n++;
			if (n > 400) begin
				error_cnt++;
				$display("unexpected at %0t: operation never finished", $time);
				stop_test();
			end
		end while (rd[0] !== 1'b0);
		if (m != 32'h0000_0000) rd_chk(REG_RESULT, v, m);
		if (irqs != 2'b00) begin
			rd_chk(REG_IRQ_ST, {30'h0000_0000, irqs}, 32'h0000_0003);
			apb(1'b1, REG_IRQ_ST, 32'h0000_0003, 1'b0);
		end
	endtask
	////////////////////////////////////////
	initial begin
		{reset_n, psel, penable, pwrite, chk, slow, fail_prog, supply_bad} = '0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		error_cnt = 0;
		checks = 0;
		wd = 16'($urandom(32'h17a3));
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		cmp({27'h000_0000, chip_en_n, out_en_n, write_en_n, dq_oe, irq}, 32'h0000_001C, "idle");
		rd_chk(REG_IRQ_ST, 32'h0000_0000, 32'h0000_0003);
		apb(1'b0, 8'h00_3C, 32'h0000_0000, 1'b0);
		cmp({31'h0, perr}, 32'h0000_0001, "unmapped error");
		cmp(rd, 32'h0000_0000, "unmapped data");
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			slow <= i[0];
			run(lk_ops[i], 23'h05_0000, 16'h0000, 32'h0, M_ERR, 2'b01);
			cmp({30'h0, part.mode}, 32'h0000_0000, "array mode");
			run(OP_LOCK_STATUS, 23'h05_0000, 16'h0000, {30'h0, lk_exp[i]}, 32'h3, 2'b01);
		end
		$display("test locking done");
		wd = 16'($urandom());
		run(OP_PROGRAM, 23'h01_0010, wd, 32'h0, M_ERR, 2'b01);
		run(OP_READ_WORD, 23'h01_0010, 16'h0000, {16'h0, wd}, 32'hFFFF, 2'b01);
		run(OP_PROGRAM, 23'h05_0004, wd, M_ERR, M_ERR, 2'b11);
		run(OP_READ_WORD, 23'h05_0004, 16'h0000, 32'hFFFF, 32'hFFFF, 2'b01);
		run(OP_PROGRAM, 23'h01_0012, ~wd, M_ERR, M_ERR, 2'b11);
		run(OP_CLEAR_STATUS, 23'h0, 16'h0000, 32'h0, 32'h0, 2'b01);
		fail_prog <= 1'b1;
		run(OP_PROGRAM, 23'h01_0014, wd, M_ERR, M_ERR, 2'b11);
		fail_prog <= 1'b0;
		run(OP_PROGRAM, 23'h01_0016, wd, M_ERR, M_ERR, 2'b11);
		run(OP_CLEAR_STATUS, 23'h0, 16'h0000, 32'h0, 32'h0, 2'b01);
		run(OP_PROGRAM, 23'h01_0016, wd, 32'h0, M_ERR, 2'b01);
		$display("test program flags done");
		run(OP_PROT_PROGRAM, 23'h00_0080, wd, 32'h0, M_ERR, 2'b01);
		cmp({16'h0, part.prot[23'h00_0080]}, {16'h0, wd}, "protection word");
		run(OP_PROT_PROGRAM, 23'h00_0200, wd, M_ERR, M_ERR, 2'b11);
		run(OP_CLEAR_STATUS, 23'h0, 16'h0000, 32'h0, 32'h0, 2'b01);
		supply_bad <= 1'b1;
		run(OP_PROGRAM, 23'h01_0020, wd, M_ERR, M_ERR, 2'b11);
		supply_bad <= 1'b0;
		run(OP_PROGRAM, 23'h01_0022, wd, M_ERR, M_ERR, 2'b11);
		run(OP_READ_WORD, 23'h01_0022, 16'h0000, 32'hFFFF, 32'hFFFF, 2'b01);
		run(OP_CLEAR_STATUS, 23'h0, 16'h0000, 32'h0, 32'h0, 2'b01);
		$display("test protection and supply done");
		run(OP_ERASE_SUSPEND, 23'h03_0000, 16'h0000, 32'h0, M_ERR, 2'b01);
		cmp({16'h0, part.hist1, part.hist0}, 32'h0000_70B0, "suspend order");
		run(OP_PROGRAM, 23'h02_0000, wd, 32'h0, M_ERR, 2'b01);
		run(OP_ERASE_RESUME, 23'h03_0000, 16'h0000, 32'h0, 32'h0, 2'b01);
		cmp({31'h0, part.susp}, 32'h0000_0000, "resumed");
		$display("test suspend done");
		apb(1'b1, REG_IRQ_MK, 32'h0000_0002, 1'b0);
		run(OP_READ_ARRAY, 23'h0, 16'h0000, 32'h0, 32'h0, 2'b00);
		cmp({31'h0, irq}, 32'h0000_0000, "masked irq");
		apb(1'b1, REG_IRQ_MK, 32'h0000_0001, 1'b0);
		cmp({31'h0, irq}, 32'h0000_0001, "unmasked irq");
		apb(1'b1, REG_IRQ_ST, 32'h0000_0001, 1'b0);
		cmp({31'h0, irq}, 32'h0000_0000, "cleared irq");
		$display("test interrupt done");
		repeat (2) @(posedge mclk);
		stop_test();
	end
endmodule // pcm_command_sequencer_bench
